/* hdl/alarm_eval.sv */
// One alarm channel: threshold or rate-of-change comparison on fresh samples.
// Assumes eval pulses once per sample period with the selected source value.
`timescale 1ns/1ps
`default_nettype none
module alarm_eval
	import tilt_alarm_pkg::*;
#(
	parameter int DATA_W = THR_DATA_W
)(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic eval,
	input wire logic enable,
	input wire logic rate_of_change_mode,
	input wire logic [REG_W-1:0] threshold,
	input wire logic [WIN_W-1:0] window,
	input wire logic signed [DATA_W-1:0] value,
	output logic active
);
	localparam int HIST_D = 2 ** WIN_W;
	localparam int PROD_W = DATA_W + WIN_W + 2;
	logic signed [DATA_W-1:0] hist [HIST_D];
	logic [WIN_W-1:0] wr_ptr_r;
	logic [WIN_W:0] fill_r;
	logic [WIN_W-1:0] win_eff;
	logic signed [DATA_W-1:0] oldest;
	logic signed [DATA_W-1:0] thr;
	logic signed [PROD_W-1:0] lhs;
	logic signed [PROD_W-1:0] rhs;
	logic hit;
	logic active_r;

	assign win_eff = (window == '0) ? WIN_W'(1) : window; // see RULE_19
	assign oldest = hist[wr_ptr_r - win_eff];
	assign thr = signed'(threshold[DATA_W-1:0]);

	// Comparing the change against threshold times the window avoids a divider.
	always_comb
	begin
		if (rate_of_change_mode)
		begin
			lhs = PROD_W'(value) - PROD_W'(oldest); // see RULE_02
			rhs = PROD_W'(thr) * PROD_W'(signed'({1'b0, win_eff}));
		end
		else
		begin
			lhs = PROD_W'(value);
			rhs = PROD_W'(thr);
		end
		hit = threshold[THR_GT_BIT] ? (lhs > rhs) : (lhs < rhs); // see RULE_15
	end

	always_ff @(posedge clk)
	begin
		if (eval)
			hist[wr_ptr_r] <= value;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ptr_r <= '0;
			fill_r <= '0;
		end
		else if (eval)
		begin
			wr_ptr_r <= wr_ptr_r + WIN_W'(1);
			if (fill_r != (WIN_W+1)'(HIST_D))
				fill_r <= fill_r + (WIN_W+1)'(1);
		end
	end

	// Rate mode stays quiet until the history covers the whole window.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			active_r <= 1'b0;
		else if (!enable)
			active_r <= 1'b0; // see RULE_05
		else if (eval)
			active_r <= hit && (!rate_of_change_mode || fill_r >= {1'b0, win_eff});
	end

	assign active = active_r;

	alarm_off_a: assert property (@(posedge clk) disable iff (!rst_n) !enable |=> !active) // see RULE_05
		else $error("alarm active while its source is disabled");
	thr_mode_a: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_15
		eval && enable && !rate_of_change_mode |=> active == $past(hit))
		else $error("threshold alarm does not follow the comparison");
	roc_fill_a: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_02
		eval && enable && rate_of_change_mode && fill_r < {1'b0, win_eff} |=> !active)
		else $error("rate alarm raised before the window filled");
endmodule
`default_nettype wire

/* hdl/spi_link_if.sv */
// Carrier between the serial front end and the register core.
// Assumes the two ends sit in different clock domains; no clocking here.
`timescale 1ns/1ps
`default_nettype none
interface spi_link_if
	import tilt_alarm_pkg::*;
();
	logic [FRAME_BITS-1:0] frame_word;
	logic frame_toggle;
	logic [FRAME_BITS-1:0] read_word;
	modport link (output frame_word, output frame_toggle, input read_word);
	modport core (input frame_word, input frame_toggle, output read_word);
endinterface
`default_nettype wire

/* hdl/spi_link_slave.sv */
// Serial front end on the host's clock: 16-bit frames, mode 3, MSB first.
// Assumes the read word from the core is stable while a frame is running.
`timescale 1ns/1ps
`default_nettype none
module spi_link_slave
	import tilt_alarm_pkg::*;
(
	input wire logic rst_n,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	output logic miso_o,
	output logic miso_oe,
	spi_link_if.link link
);
	localparam int CNT_W = $clog2(FRAME_BITS);
	localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(FRAME_BITS - 1);
	logic [CNT_W-1:0] bit_cnt_r;
	logic [FRAME_BITS-2:0] shift_r;
	logic [FRAME_BITS-1:0] word_r;
	logic tog_r;

	// The select line ends the frame, so no sclk edge is needed after the last bit.
	always_ff @(posedge sclk or posedge cs_n)
	begin
		if (cs_n)
			bit_cnt_r <= '0;
		else
			bit_cnt_r <= bit_cnt_r + CNT_W'(1);
	end

	always_ff @(posedge sclk or negedge rst_n)
	begin
		if (!rst_n)
			shift_r <= '0;
		else
			shift_r <= {shift_r[FRAME_BITS-3:0], mosi};
	end

	always_ff @(posedge sclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			word_r <= '0;
			tog_r <= 1'b0;
		end
		else if (bit_cnt_r == LAST_BIT)
		begin
			word_r <= {shift_r, mosi};
			tog_r <= ~tog_r;
		end
	end

	assign link.frame_word = word_r;
	assign link.frame_toggle = tog_r;
	assign miso_o = link.read_word[LAST_BIT - bit_cnt_r];
	assign miso_oe = ~cs_n;
endmodule
`default_nettype wire

/* hdl/tilt_alarm_pkg.sv */
// Shared constants and types of the alarm configuration and sample timer.
// Assumes a 200 MHz core clock and a 16-bit serial frame from the host.
package tilt_alarm_pkg;
	localparam int FRAME_BITS = 16;
	localparam int REG_W = 16;
	localparam int ADDR_W = 7;
	localparam int FRAME_WR_BIT = 15;
	localparam int FRAME_ADDR_LO = 8;
	localparam int BYTE_W = 8;
	localparam logic [6:0] ADDR_RATE_WIN = 7'h26;
	localparam logic [6:0] ADDR_ALARM_CFG = 7'h28;
	localparam logic [6:0] ADDR_SAMPLE_INT = 7'h36;
	localparam logic [15:0] RATE_WIN_RST = 16'h0000;
	localparam logic [15:0] ALARM_CFG_RST = 16'h0000;
	localparam logic [15:0] SAMPLE_INT_RST = 16'h000a;
	localparam logic [15:0] RATE_WIN_MASK = 16'h00ff;
	localparam logic [15:0] ALARM_CFG_MASK = 16'hff07;
	localparam logic [15:0] SAMPLE_INT_MASK = 16'h00ff;
	localparam int CFG_A1_ROC = 11;
	localparam int CFG_A1_SEL_LO = 8;
	localparam int CFG_ALARM_STRIDE = 4;
	localparam int CFG_PIN_EN = 2;
	localparam int CFG_PIN_POL = 1;
	localparam int CFG_PIN_LINE = 0;
	localparam int SRC_W = 3;
	localparam int WIN_W = 8;
	localparam int SI_BASE_BIT = 7;
	localparam int SI_COUNT_W = 7;
	localparam int THR_GT_BIT = 15;
	localparam int THR_DATA_W = 14;
	localparam int NUM_SRC = 7;
	localparam int NUM_ALARMS = 2;
	localparam int NUM_AUX = 2;
	localparam int PRESCALE_W = 20;
	localparam real CLK_MHZ = 200.0;
	localparam real BASE_FAST_US = 122.1;
	localparam real BASE_SLOW_MS = 3.784;
	localparam int BASE_FAST_CYC = int'(BASE_FAST_US * CLK_MHZ);
	localparam int BASE_SLOW_CYC = int'(BASE_SLOW_MS * 1000.0 * CLK_MHZ);
	typedef enum logic [SRC_W-1:0] {
		SRC_OFF, SRC_SUPPLY, SRC_XACC, SRC_YACC, SRC_AUX_ADC, SRC_TEMP, SRC_XINCL, SRC_YINCL
	} alarm_src_e;
	typedef logic [THR_DATA_W-1:0] sample_t;
endpackage

/* hdl/tilt_alarm_timer.sv */
// Alarm configuration registers, alarm output routing and sample period timer.
// Assumes sample inputs and side controls come from logic on clk, and that
// por_n is asserted together with rst_n at power-up.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RULE_01 - Alarm 2 window: low byte count, zero default
// RULE_02 - Rate mode compares averaged change with threshold
// RULE_03 - Alarm 2 window survives reset as stored value
// RULE_04 - Bit 15 selects Alarm 2 rate mode
// RULE_05 - Bits 14:12 pick Alarm 2 source, zero disables
// RULE_06 - Bit 11 selects Alarm 1 rate mode
// RULE_07 - Bits 10:8 pick Alarm 1 source, same code
// RULE_08 - Bit 2 enables pin, bit 1 sets level
// RULE_09 - Bit 0 routes pin to line one or zero
// RULE_10 - All seven outputs update together each period
// RULE_11 - Bit 7 picks 122.1 us or 3.784 ms base
// RULE_12 - Period is base times count plus one
// RULE_13 - Sample interval powers up at 0x0a
// RULE_14 - Interval kept over reset only after flash update
// RULE_15 - Threshold bit 15 chooses above or below
// RULE_16 - Alarm pin follows condition, never latches
// RULE_17 - Alarms compare instantaneous, unfiltered samples
// RULE_18 - Misc over alarm over general I/O on lines
// RULE_19 - Zero rate window counts as one sample
module tilt_alarm_timer
	import tilt_alarm_pkg::*;
#(
	parameter int FAST_BASE_CYC = BASE_FAST_CYC,
	parameter int SLOW_BASE_CYC = BASE_SLOW_CYC
)(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic por_n,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	output logic miso_o,
	output logic miso_oe,
	input wire logic [NUM_SRC-1:0][THR_DATA_W-1:0] sample_in,
	input wire logic [REG_W-1:0] alarm1_threshold,
	input wire logic [REG_W-1:0] alarm2_threshold,
	input wire logic [WIN_W-1:0] alarm1_rate_window,
	input wire logic flash_update,
	input wire logic [NUM_AUX-1:0] misc_claim,
	input wire logic [NUM_AUX-1:0] misc_value,
	input wire logic [NUM_AUX-1:0] gpio_value,
	input wire logic [NUM_AUX-1:0] gpio_oe,
	output logic [NUM_AUX-1:0] aux_o,
	output logic [NUM_AUX-1:0] aux_oe,
	output logic [NUM_ALARMS-1:0] alarm_active,
	output logic sample_update,
	output logic [NUM_SRC-1:0][THR_DATA_W-1:0] sample_out
);
	spi_link_if link ();

	logic tog_s1_r;
	logic tog_s2_r;
	logic tog_s3_r;
	logic frame_evt;
	logic [FRAME_BITS-1:0] frame_r;
	logic frame_vld_r;
	logic wr_cmd;
	logic hi_byte;
	logic [ADDR_W-1:0] reg_addr;
	logic [BYTE_W-1:0] wr_data;
	logic [FRAME_BITS-1:0] read_word_r;
	logic rst_hold_r;
	logic [REG_W-1:0] cfg_r;
	logic [REG_W-1:0] win_r;
	logic [REG_W-1:0] win_nv_r;
	logic [REG_W-1:0] si_r;
	logic [REG_W-1:0] si_nv_r;
	logic [REG_W-1:0] period_cfg_r;
	logic [PRESCALE_W-1:0] pre_r;
	logic [PRESCALE_W-1:0] base_m1;
	logic [SI_COUNT_W-1:0] per_r;
	logic base_wrap;
	logic update_r;
	logic eval_r;
	logic [NUM_SRC-1:0][THR_DATA_W-1:0] samples_r;
	logic [NUM_ALARMS-1:0] alarm_hit;
	logic any_alarm;
	logic pin_level;
	logic [NUM_AUX-1:0] aux_o_r;
	logic [NUM_AUX-1:0] aux_oe_r;

	function automatic logic [REG_W-1:0] merge_byte(input logic [REG_W-1:0] old,
		input logic hi, input logic [BYTE_W-1:0] data);
		merge_byte = hi ? {data, old[BYTE_W-1:0]} : {old[REG_W-1:BYTE_W], data};
	endfunction

	function automatic logic wr_hit(input logic [ADDR_W-1:0] target);
		wr_hit = frame_vld_r && wr_cmd && (reg_addr == target);
	endfunction

	function automatic sample_t src_value(input logic [SRC_W-1:0] sel);
		src_value = '0;
		for (int k = 0; k < NUM_SRC; k++)
		begin
			if (sel == SRC_W'(k + 1))
				src_value = samples_r[k];
		end
	endfunction

	spi_link_slave u_link (
		.rst_n(rst_n),
		.sclk(sclk),
		.cs_n(cs_n),
		.mosi(mosi),
		.miso_o(miso_o),
		.miso_oe(miso_oe),
		.link(link.link)
	);

	// The frame word only changes at the end of the next frame, long after the
	// toggle has crossed, so it is captured here without further stages.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tog_s1_r <= 1'b0;
			tog_s2_r <= 1'b0;
			tog_s3_r <= 1'b0;
		end
		else
		begin
			tog_s1_r <= link.frame_toggle;
			tog_s2_r <= tog_s1_r;
			tog_s3_r <= tog_s2_r;
		end
	end

	assign frame_evt = tog_s2_r ^ tog_s3_r;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			frame_r <= '0;
			frame_vld_r <= 1'b0;
		end
		else
		begin
			frame_vld_r <= frame_evt;
			if (frame_evt)
				frame_r <= link.frame_word;
		end
	end

	assign wr_cmd = frame_r[FRAME_WR_BIT];
	assign hi_byte = frame_r[FRAME_ADDR_LO];
	assign reg_addr = {frame_r[FRAME_WR_BIT-1:FRAME_ADDR_LO+1], 1'b0};
	assign wr_data = frame_r[BYTE_W-1:0];

	// Every frame stages its addressed register for the next frame's read-back.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			read_word_r <= '0;
		else if (frame_vld_r)
		begin
			unique case (reg_addr)
				ADDR_RATE_WIN: read_word_r <= win_r;
				ADDR_ALARM_CFG: read_word_r <= cfg_r;
				ADDR_SAMPLE_INT: read_word_r <= si_r;
				default: read_word_r <= '0;
			endcase
		end
	end

	assign link.read_word = read_word_r;

	// Working copies of stored settings are reloaded in the first cycle after reset.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rst_hold_r <= 1'b1;
		else
			rst_hold_r <= 1'b0;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			cfg_r <= ALARM_CFG_RST;
		else if (wr_hit(ADDR_ALARM_CFG))
			cfg_r <= merge_byte(cfg_r, hi_byte, wr_data) & ALARM_CFG_MASK;
	end

	always_ff @(posedge clk or negedge por_n)
	begin
		if (!por_n)
			win_nv_r <= RATE_WIN_RST;
		else if (wr_hit(ADDR_RATE_WIN))
			win_nv_r <= merge_byte(win_r, hi_byte, wr_data) & RATE_WIN_MASK; // see RULE_03
	end

	always_ff @(posedge clk or negedge por_n)
	begin
		if (!por_n)
			win_r <= RATE_WIN_RST; // see RULE_01
		else if (rst_hold_r)
			win_r <= win_nv_r; // see RULE_03
		else if (wr_hit(ADDR_RATE_WIN))
			win_r <= merge_byte(win_r, hi_byte, wr_data) & RATE_WIN_MASK; // see RULE_01
	end

	always_ff @(posedge clk or negedge por_n)
	begin
		if (!por_n)
			si_nv_r <= SAMPLE_INT_RST;
		else if (flash_update && !rst_hold_r)
			si_nv_r <= si_r; // see RULE_14
	end

	always_ff @(posedge clk or negedge por_n)
	begin
		if (!por_n)
			si_r <= SAMPLE_INT_RST; // see RULE_13
		else if (rst_hold_r)
			si_r <= si_nv_r; // see RULE_14
		else if (wr_hit(ADDR_SAMPLE_INT))
			si_r <= merge_byte(si_r, hi_byte, wr_data) & SAMPLE_INT_MASK;
	end

	// A new interval takes effect at the next period boundary, never mid-period.
	assign base_m1 = period_cfg_r[SI_BASE_BIT] ? PRESCALE_W'(SLOW_BASE_CYC - 1)
		: PRESCALE_W'(FAST_BASE_CYC - 1); // see RULE_11
	assign base_wrap = (pre_r == base_m1);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			pre_r <= '0;
		else if (base_wrap)
			pre_r <= '0;
		else
			pre_r <= pre_r + PRESCALE_W'(1);
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			per_r <= '0;
			update_r <= 1'b0;
			period_cfg_r <= SAMPLE_INT_RST;
		end
		else
		begin
			update_r <= 1'b0;
			// The working copy is reloaded at this same edge, so take the stored value.
			if (rst_hold_r)
				period_cfg_r <= si_nv_r; // see RULE_14
			if (base_wrap)
			begin
				if (per_r == period_cfg_r[SI_COUNT_W-1:0])
				begin
					per_r <= '0; // see RULE_12
					update_r <= 1'b1;
					period_cfg_r <= si_r;
				end
				else
					per_r <= per_r + SI_COUNT_W'(1);
			end
		end
	end

	assign sample_update = update_r;

	// Raw converter values are held here; averaging happens downstream only.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			samples_r <= '0;
			eval_r <= 1'b0;
		end
		else
		begin
			eval_r <= update_r;
			if (update_r)
				samples_r <= sample_in; // see RULE_10
		end
	end

	assign sample_out = samples_r;

	generate
		for (genvar i = 0; i < NUM_ALARMS; i++)
		begin : g_alarm
			localparam int SEL_LO = CFG_A1_SEL_LO + i * CFG_ALARM_STRIDE;
			localparam int ROC_BIT = CFG_A1_ROC + i * CFG_ALARM_STRIDE;
			logic [SRC_W-1:0] sel;
			assign sel = cfg_r[SEL_LO+SRC_W-1:SEL_LO]; // see RULE_05 RULE_07
			alarm_eval u_eval (
				.clk(clk),
				.rst_n(rst_n),
				.eval(eval_r),
				.enable(sel != SRC_OFF),
				.rate_of_change_mode(cfg_r[ROC_BIT]), // see RULE_04 RULE_06
				.threshold((i == 0) ? alarm1_threshold : alarm2_threshold),
				.window((i == 0) ? alarm1_rate_window : win_r[WIN_W-1:0]), // see RULE_02
				.value(src_value(sel)), // see RULE_17
				.active(alarm_hit[i])
			);
		end
	endgenerate

	assign alarm_active = alarm_hit;
	assign any_alarm = |alarm_hit;
	assign pin_level = cfg_r[CFG_PIN_POL] ? any_alarm : ~any_alarm; // see RULE_08

	// The pin is recomputed every cycle from the live condition.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aux_o_r <= '0;
			aux_oe_r <= '0;
		end
		else
		begin
			for (int j = 0; j < NUM_AUX; j++)
			begin
				if (misc_claim[j])
				begin
					aux_o_r[j] <= misc_value[j]; // see RULE_18
					aux_oe_r[j] <= 1'b1;
				end
				else if (cfg_r[CFG_PIN_EN] && (cfg_r[CFG_PIN_LINE] == j[0]))
				begin
					aux_o_r[j] <= pin_level; // see RULE_09 RULE_16
					aux_oe_r[j] <= 1'b1;
				end
				else
				begin
					aux_o_r[j] <= gpio_value[j];
					aux_oe_r[j] <= gpio_oe[j];
				end
			end
		end
	end

	assign aux_o = aux_o_r;
	assign aux_oe = aux_oe_r;

	int gap_cnt_r;
	int exp_gap_r;
	logic gap_seen_r;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			gap_cnt_r <= 0;
			exp_gap_r <= 0;
			gap_seen_r <= 1'b0;
		end
		else if (update_r)
		begin
			gap_cnt_r <= 1;
			gap_seen_r <= 1'b1;
			exp_gap_r <= (period_cfg_r[SI_BASE_BIT] ? SLOW_BASE_CYC : FAST_BASE_CYC)
				* (int'(period_cfg_r[SI_COUNT_W-1:0]) + 1);
		end
		else
			gap_cnt_r <= gap_cnt_r + 1;
	end

	period_len_a: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_12
		update_r && gap_seen_r |-> gap_cnt_r == exp_gap_r)
		else $error("sample period length differs from base times count plus one");
	update_pulse_a: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_10
		update_r |=> !update_r ##1 samples_r == $past(sample_in, 2))
		else $error("sample update is not a single pulse capturing all inputs");
	win_upper_a: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_01
		win_r[REG_W-1:WIN_W] == '0)
		else $error("upper bits of the rate window are not zero");
	win_store_a: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_03
		wr_hit(ADDR_RATE_WIN) |=> win_nv_r == win_r)
		else $error("rate window write not kept in storage");
	flash_a: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_14
		flash_update && !rst_hold_r |=> si_nv_r == $past(si_r))
		else $error("flash update did not store the sample interval");
	restore_a: assert property (@(posedge clk) // see RULE_14
		rst_hold_r && por_n && $past(por_n) |=> si_r == $past(si_nv_r) && win_r == $past(win_nv_r))
		else $error("stored settings not restored after reset");
	line_prio_a: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_18
		misc_claim[0] |=> aux_oe_r[0] && aux_o_r[0] == $past(misc_value[0]))
		else $error("miscellaneous claim lost priority on line zero");
	pin_follow_a: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_16
		cfg_r[CFG_PIN_EN] && cfg_r[CFG_PIN_LINE] && !misc_claim[1]
		|=> aux_oe_r[1] && aux_o_r[1] == $past(pin_level))
		else $error("alarm pin on line one does not track the alarm");
	pin_off_a: assert property (@(posedge clk) disable iff (!rst_n) // see RULE_08
		!cfg_r[CFG_PIN_EN] && !misc_claim[0] |=> aux_oe_r[0] == $past(gpio_oe[0]))
		else $error("disabled alarm pin still drives line zero");

	update_c: cover property (@(posedge clk) disable iff (!rst_n) update_r ##1 !update_r);
	write_c: cover property (@(posedge clk) disable iff (!rst_n) wr_hit(ADDR_ALARM_CFG));
	alarm_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(any_alarm));
	pin_c: cover property (@(posedge clk) disable iff (!rst_n)
		cfg_r[CFG_PIN_EN] && aux_oe_r[cfg_r[CFG_PIN_LINE]] && any_alarm);
endmodule
`default_nettype wire

/* testbench/spi_host_model.sv */
// Host side of the serial register link: mode 3, 16-bit frames, MSB first.
// Assumes the device answers each frame during the frame that follows it.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model
(
	output logic sclk,
	output logic cs_n,
	output logic mosi,
	input wire logic miso
);
	initial
	begin
		sclk = 1'b1;
		cs_n = 1'b1;
		mosi = 1'b0;
	end

	// The link clock stands high between frames, and mosi shows the inverse of its last
	// bit so that a device sampling outside a frame cannot pick up a stale value.
	task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
		#13;
		cs_n = 1'b0;
		#31;
		for (int i = 15; i >= 0; i--)
		begin
			sclk = 1'b0;
			mosi = tx[i];
			#62.5;
			rx[i] = miso;
			sclk = 1'b1;
			#62.5;
		end
		cs_n = 1'b1;
		mosi = ~mosi;
		#250;
	endtask
endmodule
`default_nettype wire

/* testbench/tilt_alarm_timer_tb_top.sv */
// Self-checking bench for the alarm configuration and sample timer.
// Assumes short time bases (5 and 31 cycles) set through the parameters.
`timescale 1ns/1ps
`default_nettype none
module tilt_alarm_timer_tb_top
	import tilt_alarm_pkg::*;
;
	logic clk, rst_n, por_n, flash_update, sclk, cs_n, mosi, miso_o, miso_oe, sample_update;
	logic [1:0] misc_claim, misc_value, aux_o, aux_oe, alarm_active;
	logic [NUM_SRC-1:0][THR_DATA_W-1:0] samp, sample_out;
	logic [15:0] th1, th2;
	logic [1:0] gpio_value, gpio_oe;
	logic [7:0] win1;
	logic [15:0] si_tab [4];
	logic [15:0] pin_tab [5];
	int fail_count, comparisons, n;

	spi_host_model u_spi_host_model (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso_o));

	tilt_alarm_timer #(.FAST_BASE_CYC(5), .SLOW_BASE_CYC(31)) u_tilt_alarm_timer (
		.clk(clk), .rst_n(rst_n), .por_n(por_n), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
		.miso_o(miso_o), .miso_oe(miso_oe), .sample_in(samp), .alarm1_threshold(th1),
		.alarm2_threshold(th2), .alarm1_rate_window(win1), .flash_update(flash_update),
		.misc_claim(misc_claim), .misc_value(misc_value), .gpio_value(gpio_value),
		.gpio_oe(gpio_oe), .aux_o(aux_o), .aux_oe(aux_oe), .alarm_active(alarm_active),
		.sample_update(sample_update), .sample_out(sample_out));

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic wrap_up();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input string what, input logic [127:0] e, input logic [127:0] got);
		comparisons++;
		if (got !== e)
		begin
			$display("[ERR] %s expected %h seen %h", what, e, got);
			fail_count++;
		end
	endtask

	// A 16-bit register takes two byte frames: odd address high byte, even address low.
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		logic [15:0] rx;
		u_spi_host_model.xfer({1'b1, a | 7'h01, d[15:8]}, rx);
		u_spi_host_model.xfer({1'b1, a, d[7:0]}, rx);
	endtask

	task automatic chk_reg(input logic [6:0] a, input logic [15:0] e);
		logic [15:0] d;
		u_spi_host_model.xfer({1'b0, a, 8'h00}, d);
		u_spi_host_model.xfer({1'b0, a, 8'h00}, d);
		chk($sformatf("register %h", a), e, d);
		chk("miso_oe idle", 1'b0, miso_oe);
	endtask

	task automatic next_pulse(output int cnt);
		@(posedge clk);
		#1;
		cnt = 1;
		while (sample_update !== 1'b1 && cnt < 3000)
		begin
			@(posedge clk);
			#1;
			cnt++;
		end
		if (cnt >= 3000)
		begin
			chk("sample_update pulse", 1, 0);
			wrap_up();
		end
	endtask

	// Waits for a period boundary, then for the alarm and line stages behind it.
	task automatic settle();
		int c;
		next_pulse(c);
		repeat (3) @(posedge clk);
		#1;
	endtask

	task automatic do_reset(input logic with_por);
		@(posedge clk);
		#1;
		rst_n = 1'b0;
		por_n = ~with_por;
		repeat (3) @(posedge clk);
		#1;
		rst_n = 1'b1;
		por_n = 1'b1;
		repeat (10) @(posedge clk);
	endtask

	initial
	begin
		rst_n = 1'b0;
		por_n = 1'b0;
		flash_update = 1'b0;
		misc_claim = 2'b00;
		misc_value = 2'b00;
		gpio_value = 2'b00;
		gpio_oe = 2'b00;
		win1 = 8'h00;
		samp = '0;
		th1 = 16'h8096;
		th2 = 16'h8064;
		si_tab = '{16'h000a, 16'h0000, 16'h007f, 16'h0081};
		pin_tab = '{16'h074f, 16'h0583, 16'h038b, 16'h0653, 16'h07a3};
		repeat (10) @(posedge clk);
		#1;
		rst_n = 1'b1;
		por_n = 1'b1;
		repeat (10) @(posedge clk);
		chk_reg(ADDR_RATE_WIN, 16'h0000);
		chk_reg(ADDR_ALARM_CFG, 16'h0000);
		chk_reg(ADDR_SAMPLE_INT, 16'h000a);
		wr(ADDR_RATE_WIN, 16'hffff);
		chk_reg(ADDR_RATE_WIN, 16'h00ff);
		wr(ADDR_ALARM_CFG, 16'hffff);
		chk_reg(ADDR_ALARM_CFG, 16'hff07);
		wr(7'h30, 16'h1234);
		chk_reg(7'h30, 16'h0000);
		for (int i = 0; i < 4; i++)
		begin
			if (i > 0)
				wr(ADDR_SAMPLE_INT, si_tab[i]);
			next_pulse(n);
			next_pulse(n);
			next_pulse(n);
			chk("sample period", (si_tab[i][7] ? 31 : 5) * (si_tab[i][6:0] + 1), n);
		end
		// Only the selected source sits above both thresholds, so a wrong select shows.
		for (int c = 0; c < 8; c++)
		begin
			samp = '0;
			if (c != 0)
				samp[c - 1] = 14'd200;
			wr(ADDR_ALARM_CFG, {1'b0, 3'(c), 1'b0, 3'(c), 8'h06});
			settle();
			chk("sample_out", samp, sample_out);
			chk("alarm and line", {alarm_active, aux_o & aux_oe, aux_oe}, {(c != 0) ? 2'b11 : 2'b00, (c != 0) ? 4'b0101 : 4'b0001});
		end
		samp = '0;
		samp[1] = 14'd200;
		gpio_oe = 2'b11;
		for (int i = 0; i < 5; i++)
		begin
			misc_claim = pin_tab[i][5:4];
			gpio_value = pin_tab[i][7:6];
			wr(ADDR_ALARM_CFG, {8'h22, pin_tab[i][15:8]});
			settle();
			chk("line drive", {aux_o & aux_oe, aux_oe}, pin_tab[i][3:0]);
		end
		misc_claim = 2'b00;
		gpio_value = 2'b00;
		gpio_oe = 2'b00;
		th2 = 16'h8032;
		wr(ADDR_RATE_WIN, 16'h0000);
		wr(ADDR_ALARM_CFG, 16'ha206);
		settle();
		settle();
		chk("steady rate alarm", 2'b01, alarm_active);
		samp[1] = 14'd300;
		settle();
		chk("step rate alarm", 2'b11, alarm_active);
		settle();
		chk("rate alarm released", 2'b01, alarm_active);
		wr(ADDR_ALARM_CFG, 16'haa06);
		settle();
		settle();
		chk("alarm one rate mode", 2'b00, alarm_active);
		// A change of 160 over two samples stays under 150 per sample for Alarm 1 only.
		win1 = 8'h02;
		samp[1] = 14'd460;
		settle();
		chk("alarm one window", 2'b10, alarm_active);
		th1 = 16'h01f4;
		wr(ADDR_ALARM_CFG, 16'h0206);
		settle();
		chk("below threshold", 2'b01, alarm_active);
		wr(ADDR_RATE_WIN, 16'h0005);
		wr(ADDR_SAMPLE_INT, 16'h0002);
		do_reset(1'b0);
		chk_reg(ADDR_RATE_WIN, 16'h0005);
		chk_reg(ADDR_SAMPLE_INT, 16'h000a);
		chk_reg(ADDR_ALARM_CFG, 16'h0000);
		wr(ADDR_SAMPLE_INT, 16'h0002);
		@(posedge clk);
		#1;
		flash_update = 1'b1;
		@(posedge clk);
		#1;
		flash_update = 1'b0;
		do_reset(1'b0);
		chk_reg(ADDR_SAMPLE_INT, 16'h0002);
		next_pulse(n);
		next_pulse(n);
		chk("stored period", 15, n);
		do_reset(1'b1);
		chk_reg(ADDR_RATE_WIN, 16'h0000);
		chk_reg(ADDR_SAMPLE_INT, 16'h000a);
		wrap_up();
	end
endmodule
`default_nettype wire
